/* File: logic/sgcr_regs.sv */
// Gain and configuration register bank with test-mode and key protection
`timescale 1ns/100ps
`include "sgcr_cfg.svh"

module sgcr_regs #(
    parameter int NWORDS = 4
) (
    input  wire logic              core_clk,
    input  wire logic              reset,
    input  wire logic              cmd_valid,
    input  wire sgcr_pkg::sgcr_cmd_t cmd,
    input  wire logic              nv_load,
    output sgcr_pkg::sgcr_rsp_t    rsp_ff,
    output logic                   rsp_valid_ff,
    output logic                   wr_ignored_ff,
    output sgcr_pkg::sgcr_cfg_t    cfg_ff,
    output logic [NWORDS-1:0]      word_valid_ff,
    output logic                   cfg_valid_ff,
    output logic                   test_mode_ff,
    output logic                   nv_unlocked_ff,
    output logic                   halve_missing_ff
);
    import sgcr_pkg::*;

    localparam int IDXW = 2;
    localparam int I_PRI = 0;
    localparam int I_SEC = 1;
    localparam int I_AMB = 2;
    localparam int I_FIL = 3;

    ////////////////////////////////////////////////////////////////////////
    // Address maps

    localparam logic [NWORDS-1:0][7:0] REG_ADDR = {
        `SGCR_ADDR_FILTER, `SGCR_ADDR_AMB,
        `SGCR_ADDR_IR_SEC, `SGCR_ADDR_IR_PRI
    };
    localparam logic [NWORDS-1:0][7:0] NV_ADDR = {
        `SGCR_NV_FILTER, `SGCR_NV_AMB,
        `SGCR_NV_IR_SEC, `SGCR_NV_IR_PRI
    };

    logic                         is_reg_wr;
    logic                         is_reg_rd;
    logic                         is_nv_wr;
    logic                         is_nv_rd;
    logic                         test_wr;
    logic                         wp_wr;
    logic                         test_match;
    logic                         wp_match;
    logic [NWORDS-1:0]            reg_hit;
    logic [NWORDS-1:0]            nv_hit;
    logic [NWORDS-1:0]            live_wr;
    logic [IDXW-1:0]              nv_idx;
    logic                         nv_any;
    logic                         nv_wr_en;
    logic [15:0]                  nv_rd_data;
    logic [NWORDS-1:0][15:0]      nv_words;
    logic [NWORDS-1:0][15:0]      live_ff;
    logic                         nxt_ignored;
    logic                         nxt_halve_missing;

    assign is_reg_wr = cmd_valid && (cmd.op == SGCR_OP_REG_WR);
    assign is_reg_rd = cmd_valid && (cmd.op == SGCR_OP_REG_RD);
    assign is_nv_wr  = cmd_valid && (cmd.op == SGCR_OP_NV_WR);
    assign is_nv_rd  = cmd_valid && (cmd.op == SGCR_OP_NV_RD);

    // Key registers take writes whatever the mode
    assign test_wr = is_reg_wr && (cmd.addr == `SGCR_ADDR_TEST);
    assign wp_wr   = is_reg_wr &&
                     (cmd.addr[7:`SGCR_WP_SHIFT] == `SGCR_ADDR_WP_BASE);

    always_comb
    begin
        nv_idx = '0;
        nv_any = 1'b0;
        for (int k = 0; k < NWORDS; k++)
        begin
            reg_hit[k] = (cmd.addr == REG_ADDR[k]);
            nv_hit[k]  = (cmd.addr == NV_ADDR[k]);
            if (nv_hit[k])
            begin
                nv_idx = IDXW'(k);
                nv_any = 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Test mode and write-protect keys

    sgcr_key_check #(
        .WIDTH (16),
        .KEY   (`SGCR_TEST_KEY),
        .MASK  (`SGCR_TEST_MASK)
    ) u_test_key (
        .core_clk (core_clk),
        .reset    (reset),
        .wr_en    (test_wr),
        .wr_data  (cmd.data),
        .match_ff (test_match)
    );

    sgcr_key_check #(
        .WIDTH (16),
        .KEY   (`SGCR_WP_KEY),
        .MASK  (`SGCR_WP_MASK)
    ) u_wp_key (
        .core_clk (core_clk),
        .reset    (reset),
        .wr_en    (wp_wr),
        .wr_data  (cmd.data),
        .match_ff (wp_match)
    );

    assign test_mode_ff   = test_match;
    assign nv_unlocked_ff = wp_match;

    ////////////////////////////////////////////////////////////////////////
    // Nonvolatile copies

    // Key must already be held before the write arrives
    assign nv_wr_en = is_nv_wr && nv_any && wp_match;

    sgcr_nv_store #(
        .WIDTH (16),
        .DEPTH (NWORDS),
        .IDXW  (IDXW)
    ) u_nv (
        .core_clk (core_clk),
        .wr_en    (nv_wr_en),
        .wr_idx   (nv_idx),
        .wr_data  (cmd.data),
        .rd_idx   (nv_idx),
        .rd_data  (nv_rd_data),
        .words    (nv_words)
    );

    ////////////////////////////////////////////////////////////////////////
    // Live configuration words

    // Direct writes only land while test mode is held
    assign live_wr = reg_hit & {NWORDS{is_reg_wr && test_match}};

    for (genvar i = 0; i < NWORDS; i++)
    begin : g_word
        // A direct write in the same cycle as a load wins
        always_ff @(posedge core_clk or posedge reset)
        begin
            if (reset)
                live_ff[i] <= `SGCR_WORD_RESET;
            else if (live_wr[i])
                live_ff[i] <= cmd.data;
            else if (nv_load)
                live_ff[i] <= nv_words[i];
        end

        always_ff @(posedge core_clk or posedge reset)
        begin
            if (reset)
                word_valid_ff[i] <= 1'b0;
            else if (live_wr[i] || nv_load)
                word_valid_ff[i] <= 1'b1;
        end
    end

    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
            cfg_valid_ff <= 1'b0;
        else
            cfg_valid_ff <= &(word_valid_ff | live_wr |
                             {NWORDS{nv_load}});
    end

    ////////////////////////////////////////////////////////////////////////
    // Field extraction

    always_comb
    begin
        cfg_ff.reference_halve_enable =
            live_ff[I_PRI][`SGCR_HALVE_BIT];
        cfg_ff.converter_regulator_on =
            live_ff[I_PRI][`SGCR_REGUL_BIT];
        cfg_ff.quiet_mode_on =
            live_ff[I_PRI][`SGCR_QUIET_BIT];
        cfg_ff.infrared_gain_code =
            live_ff[I_PRI][`SGCR_IRGAIN_LSB +: 8];
        cfg_ff.reserved_ground_trim =
            live_ff[I_SEC][`SGCR_TRIM_LSB +: 4];
        cfg_ff.converter_reference_select =
            live_ff[I_SEC][`SGCR_DACSEL_LSB +: 3];
        cfg_ff.analog_ground_select = {
            live_ff[I_FIL][`SGCR_GND_MSB_BIT],
            live_ff[I_SEC][`SGCR_GND_LSB +: 4]
        };
        cfg_ff.ambient_reference_select =
            live_ff[I_AMB][`SGCR_AREF_LSB +: 2];
        cfg_ff.mirror_ratio_select =
            live_ff[I_AMB][`SGCR_MIRROR_LSB +: 3];
        cfg_ff.ambient_gain_code =
            live_ff[I_AMB][`SGCR_AGAIN_LSB +: 6];
        cfg_ff.filter_misc =
            live_ff[I_FIL][`SGCR_FILT_LSB +: 10];
    end

    ////////////////////////////////////////////////////////////////////////
    // Halving bit check for the high DAC references

    always_comb
    begin
        nxt_halve_missing = cfg_ff.converter_reference_select >=
                                `SGCR_DACSEL_3V5 &&
                            cfg_ff.converter_reference_select <=
                                `SGCR_DACSEL_4V5 &&
                            !cfg_ff.reference_halve_enable &&
                            cfg_valid_ff;
    end

    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
            halve_missing_ff <= 1'b0;
        else
            halve_missing_ff <= nxt_halve_missing;
    end

    ////////////////////////////////////////////////////////////////////////
    // Dropped writes

    always_comb
    begin
        nxt_ignored = 1'b0;
        if (is_reg_wr && !test_wr && !wp_wr && !test_match)
            nxt_ignored = 1'b1;
        if (is_nv_wr && !(nv_any && wp_match))
            nxt_ignored = 1'b1;
    end

    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
            wr_ignored_ff <= 1'b0;
        else
            wr_ignored_ff <= nxt_ignored;
    end

    ////////////////////////////////////////////////////////////////////////
    // Read answers

    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
            rsp_valid_ff <= 1'b0;
        else
            rsp_valid_ff <= is_reg_rd || is_nv_rd;
    end

    // None of these words reads back directly; copies come from storage
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            rsp_ff.refused <= 1'b0;
            rsp_ff.data    <= 16'h0000;
        end
        else if (is_nv_rd && nv_any)
        begin
            rsp_ff.refused <= 1'b0;
            rsp_ff.data    <= nv_rd_data;
        end
        else if (is_reg_rd || is_nv_rd)
        begin
            rsp_ff.refused <= 1'b1;
            rsp_ff.data    <= 16'h0000;
        end
    end

endmodule

/* File: logic/sgcr_cfg.svh */
// Offsets, field positions, keys and reset values of the gain register bank
`ifndef SGCR_CFG_SVH
`define SGCR_CFG_SVH

// Direct register addresses
`define SGCR_ADDR_IR_PRI      8'h00
`define SGCR_ADDR_IR_SEC      8'h01
`define SGCR_ADDR_AMB         8'h02
`define SGCR_ADDR_FILTER      8'h07
`define SGCR_ADDR_TEST        8'h10
`define SGCR_ADDR_WP_BASE     5'h03
`define SGCR_WP_SHIFT         3

// Nonvolatile locations of the copies
`define SGCR_NV_IR_PRI        8'h00
`define SGCR_NV_IR_SEC        8'h01
`define SGCR_NV_AMB           8'h02
`define SGCR_NV_FILTER        8'h07

// Unlock patterns and the bits that take part in the compare
`define SGCR_TEST_KEY         16'hb200
`define SGCR_TEST_MASK        16'hfe00
`define SGCR_WP_KEY           16'h0065
`define SGCR_WP_MASK          16'h007f

// Primary infrared word
`define SGCR_HALVE_BIT        15
`define SGCR_REGUL_BIT        14
`define SGCR_QUIET_BIT        13
`define SGCR_IRGAIN_LSB       5
// Secondary infrared word
`define SGCR_TRIM_LSB         12
`define SGCR_DACSEL_LSB       9
`define SGCR_GND_LSB          5
// Ambient chain word
`define SGCR_AREF_LSB         14
`define SGCR_MIRROR_LSB       11
`define SGCR_AGAIN_LSB        5
// Filter word
`define SGCR_GND_MSB_BIT      15
`define SGCR_FILT_LSB         5

// DAC reference codes that need the halving bit
`define SGCR_DACSEL_3V5       3'h3
`define SGCR_DACSEL_4V5       3'h5

`define SGCR_WORD_RESET       16'h0000

`endif

/* File: logic/sgcr_pkg.sv */
// Types shared by the gain register bank modules
package sgcr_pkg;

    typedef enum logic [1:0] {
        SGCR_OP_REG_WR,
        SGCR_OP_REG_RD,
        SGCR_OP_NV_WR,
        SGCR_OP_NV_RD
    } sgcr_op_t;

    typedef struct packed {
        sgcr_op_t    op;
        logic [7:0]  addr;
        logic [15:0] data;
    } sgcr_cmd_t;

    typedef struct packed {
        logic        refused;
        logic [15:0] data;
    } sgcr_rsp_t;

    typedef struct packed {
        logic       reference_halve_enable;
        logic       converter_regulator_on;
        logic       quiet_mode_on;
        logic [7:0] infrared_gain_code;
        logic [3:0] reserved_ground_trim;
        logic [2:0] converter_reference_select;
        logic [4:0] analog_ground_select;
        logic [1:0] ambient_reference_select;
        logic [2:0] mirror_ratio_select;
        logic [5:0] ambient_gain_code;
        logic [9:0] filter_misc;
    } sgcr_cfg_t;

endpackage

/* File: logic/sgcr_key_check.sv */
// Key register that flags whether the last written word matches its key
`timescale 1ns/100ps
`include "sgcr_cfg.svh"

module sgcr_key_check #(
    parameter int          WIDTH = 16,
    parameter logic [15:0] KEY   = `SGCR_TEST_KEY,
    parameter logic [15:0] MASK  = `SGCR_TEST_MASK
) (
    input  wire logic             core_clk,
    input  wire logic             reset,
    input  wire logic             wr_en,
    input  wire logic [WIDTH-1:0] wr_data,
    output logic                  match_ff
);

    logic nxt_match;

    always_comb
    begin
        nxt_match = ((wr_data & MASK[WIDTH-1:0]) ==
                     (KEY[WIDTH-1:0] & MASK[WIDTH-1:0]));
    end

    // Any write that misses the key clears the flag again
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
            match_ff <= 1'b0;
        else if (wr_en)
            match_ff <= nxt_match;
    end

endmodule

/* File: logic/sgcr_nv_store.sv */
// Flip-flop model of the nonvolatile copies, one word per index
`timescale 1ns/100ps

module sgcr_nv_store #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 4,
    parameter int IDXW  = 2
) (
    input  wire logic                        core_clk,
    input  wire logic                        wr_en,
    input  wire logic [IDXW-1:0]             wr_idx,
    input  wire logic [WIDTH-1:0]            wr_data,
    input  wire logic [IDXW-1:0]             rd_idx,
    output logic      [WIDTH-1:0]            rd_data,
    output logic      [DEPTH-1:0][WIDTH-1:0] words
);

    logic [DEPTH-1:0][WIDTH-1:0] mem_ff;

    // Contents survive reset, as nonvolatile storage does
    always_ff @(posedge core_clk)
    begin
        if (wr_en)
            mem_ff[wr_idx] <= wr_data;
    end

    assign rd_data = mem_ff[rd_idx];
    assign words   = mem_ff;

endmodule

/* File: sim/sgcr_regs_chk.sv */
// Port-level concurrent checks of the gain register bank
`timescale 1ns/100ps

module sgcr_regs_chk #(
    parameter int NWORDS = 4
) (
    input wire logic                core_clk,
    input wire logic                reset,
    input wire logic                cmd_valid,
    input wire sgcr_pkg::sgcr_cmd_t cmd,
    input wire logic                nv_load,
    input wire sgcr_pkg::sgcr_rsp_t rsp_ff,
    input wire logic                rsp_valid_ff,
    input wire logic                wr_ignored_ff,
    input wire sgcr_pkg::sgcr_cfg_t cfg_ff,
    input wire logic [NWORDS-1:0]   word_valid_ff,
    input wire logic                cfg_valid_ff,
    input wire logic                test_mode_ff,
    input wire logic                nv_unlocked_ff,
    input wire logic                halve_missing_ff
);
    import sgcr_pkg::*;

    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);

    sequence s_op(sgcr_op_t o);
        cmd_valid && cmd.op == o;
    endsequence
    sequence s_live_wr(logic [7:0] a);
        s_op(SGCR_OP_REG_WR) ##0 (cmd.addr == a && test_mode_ff);
    endsequence
    sequence s_needs_halve;
        cfg_valid_ff && !cfg_ff.reference_halve_enable
            && cfg_ff.converter_reference_select inside {3'h3, 3'h4, 3'h5};
    endsequence

    ////////////////////////////////////////////////////////////////////////
    chk_read_answer: assert property (cmd_valid
        && cmd.op inside {SGCR_OP_REG_RD, SGCR_OP_NV_RD} |=> rsp_valid_ff)
        else $error("read got no answer");
    chk_direct_read_refused: assert property (s_op(SGCR_OP_REG_RD)
        |=> rsp_ff.refused && rsp_ff.data == 16'h0000)
        else $error("direct read not refused");
    chk_locked_wr_dropped: assert property (s_op(SGCR_OP_REG_WR)
        ##0 (!test_mode_ff && cmd.addr != 8'h10 && cmd.addr[7:3] != 5'h03)
        |=> wr_ignored_ff)
        else $error("write outside test mode not dropped");
    chk_test_key_flag: assert property (s_op(SGCR_OP_REG_WR)
        ##0 cmd.addr == 8'h10
        |=> test_mode_ff == ($past(cmd.data[15:9]) == 7'h59))
        else $error("test flag wrong after key write");
    chk_nv_wr_locked: assert property (s_op(SGCR_OP_NV_WR)
        ##0 !nv_unlocked_ff |=> wr_ignored_ff)
        else $error("locked storage write not dropped");
    chk_primary_fields: assert property (s_live_wr(8'h00)
        |=> {cfg_ff.converter_regulator_on, cfg_ff.quiet_mode_on,
             cfg_ff.infrared_gain_code} == $past(cmd.data[14:5]))
        else $error("primary fields not taken");
    chk_second_fields: assert property (s_live_wr(8'h01)
        |=> {cfg_ff.converter_reference_select,
             cfg_ff.analog_ground_select[3:0]} == $past(cmd.data[11:5]))
        else $error("secondary fields not taken");
    chk_ambient_fields: assert property (s_live_wr(8'h02)
        |=> {cfg_ff.ambient_reference_select, cfg_ff.mirror_ratio_select,
             cfg_ff.ambient_gain_code} == $past(cmd.data[15:5]))
        else $error("ambient fields not taken");
    chk_halve_flag: assert property (s_needs_halve[*2]
        |=> halve_missing_ff)
        else $error("missing halving not flagged");
    chk_load_valid: assert property (nv_load && !cmd_valid
        |=> word_valid_ff == {NWORDS{1'b1}} ##1 cfg_valid_ff)
        else $error("load did not validate settings");
endmodule

bind sgcr_regs sgcr_regs_chk #(.NWORDS(NWORDS)) u_chk (
    .core_clk(core_clk), .reset(reset), .cmd_valid(cmd_valid), .cmd(cmd),
    .nv_load(nv_load), .rsp_ff(rsp_ff), .rsp_valid_ff(rsp_valid_ff),
    .wr_ignored_ff(wr_ignored_ff), .cfg_ff(cfg_ff),
    .word_valid_ff(word_valid_ff), .cfg_valid_ff(cfg_valid_ff),
    .test_mode_ff(test_mode_ff), .nv_unlocked_ff(nv_unlocked_ff),
    .halve_missing_ff(halve_missing_ff));

/* File: sim/sgcr_host_model.sv */
// Host model that issues requests to the gain register bank
`timescale 1ns/100ps

module sgcr_host_model (
    input  wire logic           core_clk,
    output sgcr_pkg::sgcr_cmd_t cmd,
    output logic                cmd_valid,
    output logic                nv_load
);
    import sgcr_pkg::*;

    initial
    begin
        cmd       = '0;
        cmd_valid = 1'b0;
        nv_load   = 1'b0;
    end

    // One request, released at its taking edge; stale address and data inverted, op kept
    task automatic send(input sgcr_op_t op, input logic [7:0] a,
                        input logic [15:0] d);
        @(posedge core_clk);
        cmd_valid <= 1'b1;
        cmd       <= '{op, a, d};
        @(posedge core_clk);
        cmd_valid <= 1'b0;
        cmd       <= '{op, ~a, ~d};
    endtask

    task automatic load();
        @(posedge core_clk);
        nv_load <= 1'b1;
        @(posedge core_clk);
        nv_load <= 1'b0;
    endtask
endmodule

/* File: sim/tb_top.sv */
// Self-checking bench for the gain register bank
`timescale 1ns/100ps
`include "sgcr_cfg.svh"

module tb_top;
    import sgcr_pkg::*;

    logic       core_clk;
    logic       reset;
    logic       cmd_valid;
    sgcr_cmd_t  cmd;
    logic       nv_load;
    sgcr_rsp_t  rsp;
    logic       rsp_valid;
    logic       wr_ignored;
    sgcr_cfg_t  cfg;
    logic [3:0] word_valid;
    logic       cfg_valid;
    logic       test_mode;
    logic       nv_unlocked;
    logic       halve_missing;
    logic [15:0] w;
    int         num_errors = 0;
    int         n_compared = 0;
    int         cycles = 0;
    logic [7:0]  gains [3] = '{8'h00, 8'hff, 8'h5a};
    logic [7:0]  nv_a  [4] = '{8'h00, 8'h01, 8'h02, 8'h07};
    logic [15:0] nv_d  [4] = '{16'h8a40, 16'h3920, 16'hd9e0, 16'h8000};

    sgcr_regs u_dut (.core_clk(core_clk), .reset(reset),
        .cmd_valid(cmd_valid), .cmd(cmd), .nv_load(nv_load), .rsp_ff(rsp),
        .rsp_valid_ff(rsp_valid), .wr_ignored_ff(wr_ignored), .cfg_ff(cfg),
        .word_valid_ff(word_valid), .cfg_valid_ff(cfg_valid),
        .test_mode_ff(test_mode), .nv_unlocked_ff(nv_unlocked),
        .halve_missing_ff(halve_missing));
    sgcr_host_model u_host (.core_clk(core_clk), .cmd(cmd),
        .cmd_valid(cmd_valid), .nv_load(nv_load));

    initial core_clk = 1'b0;
    always #50 core_clk = ~core_clk;

    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            num_errors++;
            tally_and_finish();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        u_host.send(SGCR_OP_REG_WR, a, d);
        #1;
    endtask

    task automatic rd(input sgcr_op_t op, input logic [7:0] a);
        u_host.send(op, a, 16'h0000);
        #1;
        check({15'h0, rsp_valid}, 16'h0001);
    endtask

    task automatic two_edges();
        @(posedge core_clk);
        @(posedge core_clk);
        #1;
    endtask

    task automatic tally_and_finish();
        $display("errors %0d compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        reset = 1'b1;
        repeat (6) @(posedge core_clk);
        reset <= 1'b0;
        #1;
        check({15'h0, cfg_valid}, 16'h0000);
        wr(`SGCR_ADDR_IR_PRI, 16'hffe0);
        check({15'h0, wr_ignored}, 16'h0001);
        check({12'h0, word_valid}, 16'h0000);
        for (int i = 0; i < 3; i++)
        begin
            rd(SGCR_OP_REG_RD, 8'(i));
            check({15'h0, rsp.refused}, 16'h0001);
            check(rsp.data, 16'h0000);
        end
        wr(`SGCR_ADDR_TEST, 16'hb000);
        check({15'h0, test_mode}, 16'h0000);
        wr(`SGCR_ADDR_TEST, `SGCR_TEST_KEY | 16'h01ff);
        check({15'h0, test_mode}, 16'h0001);
        for (int i = 0; i < 3; i++)
        begin
            wr(`SGCR_ADDR_IR_PRI, {1'b0, i[0], i[1], gains[i], 5'h00});
            check({6'h0, cfg.converter_regulator_on, cfg.quiet_mode_on,
                   cfg.infrared_gain_code}, {6'h0, i[0], i[1], gains[i]});
        end
        for (int i = 0; i < 4; i++)
        begin
            w = {2'(i), 3'(i * 3), 6'(i * 21), 5'h00};
            wr(`SGCR_ADDR_AMB, w);
            check({5'h0, cfg.ambient_reference_select, cfg.mirror_ratio_select,
                   cfg.ambient_gain_code}, {5'h0, w[15:5]});
        end
        wr(`SGCR_ADDR_FILTER, 16'h8000);
        for (int d = 0; d < 6; d++)
        begin
            wr(`SGCR_ADDR_IR_SEC, {4'h0, 3'(d), 4'(d + 9), 5'h00});
            check({8'h0, cfg.converter_reference_select,
                   cfg.analog_ground_select}, {8'h0, 3'(d), 1'b1, 4'(d + 9)});
            two_edges();
            check({15'h0, halve_missing}, {15'h0, d >= 3});
        end
        // Host sets halving for the high references
        wr(`SGCR_ADDR_IR_PRI, 16'h8000);
        two_edges();
        check({15'h0, halve_missing}, 16'h0000);
        check({15'h0, cfg_valid}, 16'h0001);
        u_host.send(SGCR_OP_NV_WR, 8'h00, 16'h1234);
        #1;
        check({15'h0, wr_ignored}, 16'h0001);
        wr(8'h1b, 16'h0f00 | `SGCR_WP_KEY);
        check({15'h0, nv_unlocked}, 16'h0001);
        for (int i = 0; i < 4; i++)
            u_host.send(SGCR_OP_NV_WR, nv_a[i], nv_d[i]);
        for (int i = 0; i < 4; i++)
        begin
            rd(SGCR_OP_NV_RD, nv_a[i]);
            check({15'h0, rsp.refused}, 16'h0000);
            check(rsp.data, nv_d[i]);
        end
        rd(SGCR_OP_NV_RD, 8'h05);
        check({15'h0, rsp.refused}, 16'h0001);
        wr(8'h1f, 16'h0000);
        u_host.send(SGCR_OP_NV_WR, 8'h00, 16'hdead);
        #1;
        check({15'h0, wr_ignored}, 16'h0001);
        rd(SGCR_OP_NV_RD, 8'h00);
        check(rsp.data, nv_d[0]);
        wr(`SGCR_ADDR_TEST, 16'h0000);
        wr(`SGCR_ADDR_IR_SEC, 16'h0000);
        check({15'h0, wr_ignored}, 16'h0001);
        check({13'h0, cfg.converter_reference_select}, 16'h0005);
        wr(8'h1c, `SGCR_WP_KEY);
        check({15'h0, nv_unlocked}, 16'h0001);
        u_host.load();
        #1;
        check({12'h0, word_valid}, 16'h000f);
        check({8'h0, cfg.infrared_gain_code}, {8'h0, nv_d[0][12:5]});
        check({13'h0, cfg.converter_reference_select}, 16'h0004);
        @(posedge core_clk);
        #1;
        check({15'h0, cfg_valid}, 16'h0001);
        tally_and_finish();
    end
endmodule
